//--- alarm_router_consts.vh
// constants for the alarm sub-output router
`ifndef ALARM_ROUTER_CONSTS_VH
`define ALARM_ROUTER_CONSTS_VH
`define CLK_FREQ_HZ 125000000
`define TICK_PERIOD_S 1
`define TICK_CYCLES (`CLK_FREQ_HZ * `TICK_PERIOD_S)
`define DELAY_W 10
`define DELAY_MAX 10'h03E7
`define DELAY_DEFAULT 10'h0000
`define SRC_W 3
`define SRC_NONE 3'h0
`define SRC_GEN1 3'h1
`define SRC_GEN2 3'h2
`define SRC_GEN3 3'h3
`define SRC_GEN4 3'h4
`define SRC_HEATER 3'h5
`define SRC_LOOP 3'h6
`define NUM_SRC 6
`define NUM_OUT 4
`define IDX_HEATER 4
`define IDX_LOOP 5
`define PCT_W 10
`define PCT_ZERO 10'h0000
`define PCT_FULL 10'h03E8
`define ADDR_CTRL 8'h00
`define ADDR_SELECT 8'h04
`define ADDR_POLARITY 8'h08
`define ADDR_LATCH_EN 8'h0C
`define ADDR_LATCH_STAT 8'h10
`define ADDR_OUT_STAT 8'h14
`define ADDR_IRQ_STAT 8'h18
`define ADDR_IRQ_MASK 8'h1C
`define ADDR_ON_DELAY0 8'h20
`define ADDR_OFF_DELAY0 8'h40
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- alarm_sub_output_router.v
// alarm sub-output router: delays, latches, polarity and routing to relays
`include "alarm_router_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module alarm_sub_output_router #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // alarm condition inputs from detectors (asynchronous)
    input wire [3:0] general_alarm,
    input wire heater_break_ch1,
    input wire heater_break_ch2,
    input wire loop_break_detect,
    input wire [`PCT_W-1:0] control_output,
    input wire process_value_in_deadband,
    input wire digital_input_4,
    // unit strap
    input wire out2_is_relay,
    // relay drivers
    output reg [`NUM_OUT-1:0] relay_contact,
    output reg irq,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam NS = `NUM_SRC;
    localparam DW = `DELAY_W;
    // two-stage synchronisers for everything arriving from outside the clock
    reg [9:0] sync_a;
    reg [9:0] sync_b;
    reg [`PCT_W-1:0] pct_a;
    reg [`PCT_W-1:0] pct_b;
    reg out2_relay_a;
    reg out2_relay_b;
    reg di4_last;
    // software registers
    reg out2_mode_none;
    reg [`NUM_OUT*`SRC_W-1:0] sub_output_select;
    reg [NS-1:0] contact_polarity;
    reg [NS-1:0] latch_enable;
    reg heater_break_ch2_enable;
    reg [NS*DW-1:0] on_delay_time;
    reg [NS*DW-1:0] off_delay_time;
    reg [NS-1:0] irq_mask;
    reg [NS-1:0] irq_status;
    // per-source state
    reg [NS-1:0] latch_status;
    reg [NS-1:0] alarm_out;
    reg [NS-1:0] alarm_out_q;
    reg [NS-1:0] on_counting;
    reg [NS-1:0] off_counting;
    reg [NS*DW-1:0] count;
    reg [31:0] tick_cnt;
    reg tick;
    // bus state
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire [NS-1:0] cond;
    wire [NS-1:0] release_cond;
    wire loop_release;
    wire di4_rise;
    wire do_write;
    reg [NS-1:0] clear_req;
    reg [31:0] rd_val;
    reg rd_ok;
    reg wr_ok;
    reg [`NUM_OUT-1:0] next_relay;
    // one loop index per process so that no variable has two drivers
    integer i, j, k, m, n;
    function [DW-1:0] field;
        input [NS*DW-1:0] vec;
        input integer idx;
        begin
            field = vec[idx*DW +: DW];
        end
    endfunction
    function [DW-1:0] clamp_delay;
        input [31:0] v;
        begin
            clamp_delay = (v > `DELAY_MAX) ? `DELAY_MAX : v[DW-1:0];
        end
    endfunction
    assign loop_release = (pct_b != `PCT_ZERO && pct_b != `PCT_FULL) || sync_b[8];
    assign cond[3:0] = sync_b[3:0];
    assign cond[`IDX_HEATER] = sync_b[4] | (sync_b[5] & heater_break_ch2_enable);
    assign cond[`IDX_LOOP] = sync_b[6] & ~loop_release;
    assign release_cond = ~cond;
    assign di4_rise = sync_b[9] & ~di4_last;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    always @(posedge aclk) begin
        sync_a <= {digital_input_4, process_value_in_deadband, 1'b0, loop_break_detect,
                   heater_break_ch2, heater_break_ch1, general_alarm};
        sync_b <= sync_a;
        pct_a <= control_output;
        pct_b <= pct_a;
        out2_relay_a <= out2_is_relay;
        out2_relay_b <= out2_relay_a;
        di4_last <= sync_b[9];
    end

    // seconds tick
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
    end
    // latch-clear requests from software writes and the digital input
    always @* begin
        clear_req = {NS{1'b0}};
        if (do_write && aw_addr == `ADDR_LATCH_STAT && w_strb[0]) begin
            clear_req = ~w_data[NS-1:0];
        end
        if (di4_rise) begin
            clear_req[`IDX_HEATER] = 1'b1;
        end
    end

    // delay engines, one per source
    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_out <= {NS{1'b0}};
            on_counting <= {NS{1'b0}};
            off_counting <= {NS{1'b0}};
            latch_status <= {NS{1'b0}};
            count <= {NS*DW{1'b0}};
        end else begin
            for (i = 0; i < NS; i = i + 1) begin
                if (cond[i] && latch_enable[i]) begin
                    latch_status[i] <= 1'b1;
                end else if (clear_req[i] && release_cond[i] && !off_counting[i]) begin
                    latch_status[i] <= 1'b0;
                end
                if (cond[i]) begin
                    off_counting[i] <= 1'b0;
                    if (!alarm_out[i]) begin
                        if (field(on_delay_time, i) == `DELAY_DEFAULT) begin
                            alarm_out[i] <= 1'b1;
                        end else if (!on_counting[i]) begin
                            on_counting[i] <= 1'b1;
                            count[i*DW +: DW] <= field(on_delay_time, i);
                        end else if (tick) begin
                            if (field(count, i) == 1) begin
                                alarm_out[i] <= 1'b1;
                                on_counting[i] <= 1'b0;
                            end
                            count[i*DW +: DW] <= field(count, i) - 1'b1;
                        end
                    end
                end else begin
                    on_counting[i] <= 1'b0;
                    if (alarm_out[i] && !latch_status[i]) begin
                        if (field(off_delay_time, i) == `DELAY_DEFAULT) begin
                            alarm_out[i] <= 1'b0;
                        end else if (!off_counting[i]) begin
                            off_counting[i] <= 1'b1;
                            count[i*DW +: DW] <= field(off_delay_time, i);
                        end else if (tick) begin
                            if (field(count, i) == 1) begin
                                alarm_out[i] <= 1'b0;
                                off_counting[i] <= 1'b0;
                            end
                            count[i*DW +: DW] <= field(count, i) - 1'b1;
                        end
                    end else begin
                        off_counting[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // routing and contact polarity
    always @* begin
        for (j = 0; j < `NUM_OUT; j = j + 1) begin
            case (sub_output_select[j*`SRC_W +: `SRC_W])
                `SRC_GEN1, `SRC_GEN2, `SRC_GEN3, `SRC_GEN4, `SRC_HEATER, `SRC_LOOP: begin
                    next_relay[j] = alarm_out[sub_output_select[j*`SRC_W +: `SRC_W] - 1'b1] ^
                                    contact_polarity[sub_output_select[j*`SRC_W +: `SRC_W] - 1'b1];
                end
                default: begin
                    next_relay[j] = 1'b0;
                end
            endcase
        end
        if (!(out2_relay_b && out2_mode_none)) begin
            next_relay[2] = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            relay_contact <= {`NUM_OUT{1'b0}};
            irq <= 1'b0;
            alarm_out_q <= {NS{1'b0}};
        end else begin
            relay_contact <= next_relay;
            irq <= |(irq_status & irq_mask);
            alarm_out_q <= alarm_out;
        end
    end

    // register read decode
    always @* begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `ADDR_CTRL: rd_val = {30'h0000_0000, heater_break_ch2_enable, out2_mode_none};
            `ADDR_SELECT: rd_val = {20'h0_0000, sub_output_select};
            `ADDR_POLARITY: rd_val = {26'h000_0000, contact_polarity};
            `ADDR_LATCH_EN: rd_val = {26'h000_0000, latch_enable};
            `ADDR_LATCH_STAT: rd_val = {26'h000_0000, latch_status};
            `ADDR_OUT_STAT: rd_val = {26'h000_0000, alarm_out};
            `ADDR_IRQ_STAT: rd_val = {26'h000_0000, irq_status};
            `ADDR_IRQ_MASK: rd_val = {26'h000_0000, irq_mask};
            default: begin
                rd_ok = 1'b0;
                for (k = 0; k < NS; k = k + 1) begin
                    if (s_axi_araddr == `ADDR_ON_DELAY0 + 4 * k) begin
                        rd_val = {22'h00_0000, field(on_delay_time, k)};
                        rd_ok = 1'b1;
                    end
                    if (s_axi_araddr == `ADDR_OFF_DELAY0 + 4 * k) begin
                        rd_val = {22'h00_0000, field(off_delay_time, k)};
                        rd_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    always @* begin
        wr_ok = (aw_addr <= `ADDR_IRQ_MASK && aw_addr[1:0] == 2'b00 && aw_addr != `ADDR_OUT_STAT);
        for (m = 0; m < NS; m = m + 1) begin
            if (aw_addr == `ADDR_ON_DELAY0 + 4 * m || aw_addr == `ADDR_OFF_DELAY0 + 4 * m) begin
                wr_ok = 1'b1;
            end
        end
    end

    // axi4-lite slave and register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            out2_mode_none <= 1'b0;
            sub_output_select <= {`SRC_GEN4, `SRC_GEN3, `SRC_GEN2, `SRC_GEN1};
            contact_polarity <= {NS{1'b0}};
            latch_enable <= {NS{1'b0}};
            heater_break_ch2_enable <= 1'b0;
            on_delay_time <= {NS*DW{1'b0}};
            off_delay_time <= {NS*DW{1'b0}};
            irq_mask <= {NS{1'b0}};
            irq_status <= {NS{1'b0}};
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // hardware set wins over a write-one clear in the same cycle
            irq_status <= (irq_status & ~((do_write && aw_addr == `ADDR_IRQ_STAT && w_strb[0]) ?
                          w_data[NS-1:0] : {NS{1'b0}})) | (alarm_out & ~alarm_out_q);
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                if (w_strb[0]) begin
                    case (aw_addr)
                        `ADDR_CTRL: {heater_break_ch2_enable, out2_mode_none} <= w_data[1:0];
                        `ADDR_SELECT: sub_output_select[7:0] <= w_data[7:0];
                        `ADDR_POLARITY: contact_polarity <= w_data[NS-1:0];
                        `ADDR_LATCH_EN: latch_enable <= w_data[NS-1:0];
                        `ADDR_IRQ_MASK: irq_mask <= w_data[NS-1:0];
                        default: begin
                            for (n = 0; n < NS; n = n + 1) begin
                                if (aw_addr == `ADDR_ON_DELAY0 + 4 * n) begin
                                    on_delay_time[n*DW +: DW] <= clamp_delay(w_data);
                                end
                                if (aw_addr == `ADDR_OFF_DELAY0 + 4 * n) begin
                                    off_delay_time[n*DW +: DW] <= clamp_delay(w_data);
                                end
                            end
                        end
                    endcase
                end
                if (w_strb[1] && aw_addr == `ADDR_SELECT) begin
                    sub_output_select[11:8] <= w_data[11:8];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- router_sva.sv
// port-level assertions for the alarm router
`include "alarm_router_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module router_sva #(
    parameter TICK_CYCLES = 10
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // relay side
    input wire [3:0] relay_contact,
    input wire irq,
    // register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_outputs_clear: assert property ($rose(aresetn) |-> relay_contact == 4'h0 && !irq)
        else $error("outputs not clear after reset");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not two cycles later");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed");
    a_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp == `RESP_OKAY || s_axi_rresp == `RESP_SLVERR)
        else $error("illegal read response");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
    cover property (irq);
    cover property (relay_contact != 4'h0);
endmodule
bind alarm_sub_output_router router_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.aclk, .aresetn, .relay_contact,
    .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- field_model.sv
// alarm detectors and process signals feeding the router
`timescale 1ns/1ps
`default_nettype none
module field_model (
    // clock
    input wire logic aclk,
    // scenario requests
    input wire logic [8:0] req,
    input wire logic [9:0] co_req,
    // detector levels
    output logic [3:0] general_alarm,
    output logic heater_break_ch1,
    output logic heater_break_ch2,
    output logic loop_break_detect,
    output logic [9:0] control_output,
    output logic process_value_in_deadband,
    output logic digital_input_4
);
    // detectors sample the scenario a cycle late, as a real comparator would
    always @(posedge aclk) begin
        {digital_input_4, process_value_in_deadband, loop_break_detect} <= req[8:6];
        {heater_break_ch2, heater_break_ch1, general_alarm} <= req[5:0];
        control_output <= co_req;
    end
endmodule
`default_nettype wire

//--- tb_alarm_sub_output_router.sv
// self-checking bench for the alarm router
`include "alarm_router_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_sub_output_router;
    localparam int T = 10;
    logic aclk, aresetn, out2_is_relay, irq, heater_break_ch1, heater_break_ch2, loop_break_detect;
    logic process_value_in_deadband, digital_input_4;
    logic [8:0] req;
    logic [9:0] co_req, control_output;
    logic [3:0] general_alarm, relay_contact, s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, word;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, ctrl;
    logic [5:0] pol;
    int bad_count, num_checks, cycles, seed, s, c;
    int sel[4];
    int lsrc[3] = '{1, 5, 6};
    field_model u_field (.aclk, .req, .co_req, .general_alarm, .heater_break_ch1, .heater_break_ch2,
        .loop_break_detect, .control_output, .process_value_in_deadband, .digital_input_4);
    alarm_sub_output_router #(.TICK_CYCLES(T)) dut (.aclk, .aresetn, .general_alarm, .heater_break_ch1,
        .heater_break_ch2, .loop_break_detect, .control_output, .process_value_in_deadband, .digital_input_4,
        .out2_is_relay, .relay_contact, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // a hung handshake would otherwise stall the run forever
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_relay(input logic [3:0] exp);
        num_checks++;
        if (relay_contact !== exp) begin
            bad_count++;
            $display("Error at %0t: relays %b expected %b", $time, relay_contact, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, resp);
        chk_word(resp, `RESP_OKAY);
    endtask
    // reference: zero-delay routing of the requested conditions
    function automatic logic [3:0] model();
        logic [6:0] v;
        logic [3:0] m;
        int j;
        v = {req[6] && !req[7] && (co_req == 0 || co_req == 1000), req[4] || (req[5] && ctrl[1]), req[3:0], 1'b0};
        for (j = 0; j < 4; j++) begin
            // an unusable third output stays open whatever its polarity
            m[j] = (j != 2 || (out2_is_relay && ctrl[0])) && (v[sel[j]] ^ (sel[j] != 0 && pol[sel[j] - 1]));
        end
        return m;
    endfunction
    function automatic logic [8:0] srcreq(input int k);
        return 9'(k == 0 ? 0 : k < 5 ? 1 << (k - 1) : k == 5 ? 16 : 64);
    endfunction
    task automatic go(input logic [8:0] q, input logic [9:0] co);
        req <= q;
        co_req <= co;
        repeat (8) @(posedge aclk);
        chk_relay(model());
    endtask
    initial begin
        seed = 32'h4ef9;
        {aresetn, out2_is_relay, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
        {req, co_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ctrl, pol} = 0;
        s_axi_wstrb = 4'hf;
        sel = '{1, 2, 3, 4};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ADDR_POLARITY, word, resp);
        chk_word(word, 0);
        rd(`ADDR_LATCH_EN, word, resp);
        chk_word(word, 0);
        rd(`ADDR_ON_DELAY0, word, resp);
        chk_word(word, 0);
        rd(8'hfc, word, resp);
        chk_word(resp, `RESP_SLVERR);
        wr(`ADDR_OUT_STAT, 1, resp);
        chk_word(resp, `RESP_SLVERR);
        for (c = 1; c < 5; c++) go(srcreq(c), 0);
        for (s = 0; s < 3; s++) begin
            out2_is_relay <= s > 0;
            if (s == 2) cfg(`ADDR_CTRL, 1);
            ctrl[0] = s == 2;
            go(9'h004, 0);
        end
        $display("test routing done");
        for (s = 0; s < 7; s++) begin
            sel[0] = s;
            cfg(`ADDR_SELECT, 32'h0000_08d0 | s);
            for (c = 0; c < 7; c++) go(srcreq(c), 0);
        end
        pol = 6'h3f;
        cfg(`ADDR_POLARITY, pol);
        go(0, 0);
        go(9'h001, 0);
        out2_is_relay <= 1'b0;
        go(0, 0);
        out2_is_relay <= 1'b1;
        pol = 0;
        cfg(`ADDR_POLARITY, 0);
        sel[0] = 6;
        cfg(`ADDR_SELECT, 32'h0000_08d6);
        go(9'h040, 10'(1 + {$random(seed)} % 999));
        go(9'h040, 1000);
        go(9'h0c0, 0);
        go(9'h040, 0);
        sel[0] = 5;
        cfg(`ADDR_SELECT, 32'h0000_08d5);
        go(9'h020, 0);
        ctrl = 2'h3;
        cfg(`ADDR_CTRL, 3);
        go(9'h020, 0);
        $display("test select done");
        foreach (lsrc[k]) begin
            s = lsrc[k];
            sel[0] = s;
            cfg(`ADDR_SELECT, 32'h0000_08d0 | s);
            cfg(`ADDR_LATCH_EN, 1 << (s - 1));
            go(srcreq(s), 0);
            req <= 0;
            repeat (8) @(posedge aclk);
            chk_relay(4'h1);
            rd(`ADDR_LATCH_STAT, word, resp);
            chk_word(word, 1 << (s - 1));
            if (s == 5) req <= 9'h100;
            else cfg(`ADDR_LATCH_STAT, 0);
            repeat (8) @(posedge aclk);
            chk_relay(4'h0);
        end
        cfg(`ADDR_LATCH_EN, 0);
        sel[0] = 1;
        cfg(`ADDR_SELECT, 32'h0000_08d1);
        $display("test latch done");
        cfg(`ADDR_ON_DELAY0, 3);
        req <= 9'h001;
        repeat (15) @(posedge aclk);
        chk_relay(4'h0);
        repeat (33) @(posedge aclk);
        chk_relay(4'h1);
        cfg(`ADDR_ON_DELAY0, 0);
        cfg(`ADDR_OFF_DELAY0, 3);
        req <= 0;
        repeat (15) @(posedge aclk);
        chk_relay(4'h1);
        req <= 9'h001;
        repeat (50) @(posedge aclk);
        chk_relay(4'h1);
        req <= 0;
        repeat (15) @(posedge aclk);
        chk_relay(4'h1);
        repeat (33) @(posedge aclk);
        chk_relay(4'h0);
        $display("test delay done");
        cfg(`ADDR_IRQ_MASK, 0);
        cfg(`ADDR_IRQ_STAT, 32'h0000_003f);
        go(9'h001, 0);
        chk_word(irq, 0);
        rd(`ADDR_IRQ_STAT, word, resp);
        chk_word(word & 1, 1);
        cfg(`ADDR_IRQ_MASK, 1);
        repeat (2) @(posedge aclk);
        chk_word(irq, 1);
        cfg(`ADDR_IRQ_STAT, 1);
        repeat (2) @(posedge aclk);
        chk_word(irq, 0);
        $display("test irq done");
        cfg(`ADDR_LATCH_EN, 1);
        req <= 0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        chk_relay(4'h0);
        rd(`ADDR_LATCH_STAT, word, resp);
        chk_word(word, 0);
        $display("test reset done");
        stop_test();
    end
endmodule
`default_nettype wire
